// file: core/ffbp_regs.vh
// Constants for the fetch and branch-prediction front end.
// Assumes inclusion by core/ffbp_frontend.v, core/ffbp_ras.v and the sim props and bench.
`ifndef FFBP_REGS_VH
`define FFBP_REGS_VH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define FFBP_ADDR_W        32
`define FFBP_CHUNK_BYTES   32
`define FFBP_CHUNK_LSB     5
`define FFBP_LINE_LSB      6
`define FFBP_SECTOR_BYTES  128
`define FFBP_RAS_DEPTH     16
`define FFBP_TABLE_DEPTH   64
`define FFBP_CACHE_UOPS    12288
`define FFBP_UOPS_PER_CYC  3
`define FFBP_UCODE_STALL   1
`define FFBP_SLOW_GAP      2

// ----------------------------------------------------------------
// Branch kinds carried with a decoded branch
// ----------------------------------------------------------------
`define FFBP_BR_NONE       3'h0
`define FFBP_BR_COND       3'h1
`define FFBP_BR_CALL       3'h2
`define FFBP_BR_RET        3'h3
`define FFBP_BR_INDIR      3'h4
`define FFBP_BR_FAR        3'h5

`endif

// file: core/ffbp_ras.v
// Return address stack: push on call, pop on return.
// Assumes one push or one pop per cycle; overflow wraps and drops the oldest.
`timescale 1ns/1ps
`include "ffbp_regs.vh"

module ffbp_ras #(
    parameter DEPTH = `FFBP_RAS_DEPTH,
    parameter AW    = `FFBP_ADDR_W,
    parameter PW    = 4
) (
    // Clock and reset
    input  wire          clk,
    input  wire          nrst,
    input  wire          ce,
    // Control
    input  wire          push,
    input  wire          pop,
    input  wire          flush,
    input  wire [AW-1:0] push_addr,
    // Prediction
    output wire [AW-1:0] top_addr,
    output wire          top_valid
);

    reg  [AW-1:0] stack [0:DEPTH-1];
    reg  [PW-1:0] ptr;
    reg  [PW:0]   fill;
    wire [PW-1:0] top_idx = ptr - {{(PW-1){1'b0}}, 1'b1};

    assign top_addr  = stack[top_idx];
    assign top_valid = (fill != {(PW+1){1'b0}});

    // ----------------------------------------------------------------
    // Entries
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
            localparam integer IDX = i;
            always @(posedge clk or negedge nrst) begin
                if (!nrst)
                    stack[i] <= {AW{1'b0}};
                else if (ce && push && !flush && ptr == IDX[PW-1:0])
                    stack[i] <= push_addr;
            end
        end
    endgenerate

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ptr  <= {PW{1'b0}};
            fill <= {(PW+1){1'b0}};
        end else if (ce) begin
            if (flush) begin
                // Stack contents past a redirect are untrustworthy
                ptr  <= {PW{1'b0}};
                fill <= {(PW+1){1'b0}};
            end else if (push) begin
                ptr <= ptr + {{(PW-1){1'b0}}, 1'b1};
                if (fill != DEPTH[PW:0])
                    fill <= fill + {{PW{1'b0}}, 1'b1};
            end else if (pop && top_valid) begin
                ptr  <= top_idx;
                fill <= fill - {{PW{1'b0}}, 1'b1};
            end
        end
    end

endmodule // ffbp_ras

// file: core/ffbp_frontend.v
// Front end: predicted-path fetch, single decoder with microcode fallback,
// decoded-op cache delivery and branch prediction with retire update.
// Assumes the memory side answers fetch requests and the execution core
// reports decoded branches, retirements and mispredictions on this clock.
`timescale 1ns/1ps
`include "ffbp_regs.vh"

// Contract
// - Fetch follows the target table's predicted path in 32-byte chunks from each target.
// - A line miss also fetches the other line of the same aligned 128-byte sector.
// - There is one decoder and it takes at most one instruction per clock.
// - Instructions needing microcode take their ops from the microcode store at extra cost.
// - The op cache holds up to 12K decoded ops and delivers at most three per cycle.
// - When ops are not held as traces, a microcode flow is delivered instead.
// - A correct prediction costs no delay; a misprediction costs about the pipe depth.
// - Near conditionals, calls and returns are predicted, indirects only with a valid table entry; far transfers never.
// - Direction and target come from history and target table by linear address.
// - With no valid table entry, backward conditionals go taken and forward not taken.
// - Returns are predicted taken from a 16-entry return address stack.
// - A retiring branch sends its resolved target and the table stores it unless mispredict is raised in the same cycle.
// - Traces continue across predicted-taken branches so target shares a line.
// - A load predicted dependent takes store data; if false it waits for memory data.
// - Non-pipelined units never accept ops on consecutive cycles.
module ffbp_frontend #(
    parameter AW      = `FFBP_ADDR_W,
    parameter TDEPTH  = `FFBP_TABLE_DEPTH,
    parameter TIW     = 6,
    parameter UOPS    = `FFBP_UOPS_PER_CYC
) (
    // Clock and reset
    input  wire              clk,
    input  wire              nrst,
    input  wire              ce,
    // Instruction memory side
    output reg               fetch_req,
    output reg  [AW-1:0]     fetch_addr,
    input  wire              fetch_ack,
    input  wire              fetch_miss,
    output reg               sector_req,
    output reg  [AW-1:0]     sector_addr,
    // Decoder input: one instruction
    input  wire              dec_valid,
    input  wire [AW-1:0]     dec_pc,
    input  wire [2:0]        dec_kind,
    input  wire [AW-1:0]     dec_disp,
    input  wire              dec_complex,
    input  wire              dec_trace_hit,
    input  wire [1:0]        dec_trace_count,
    output reg               dec_ready,
    // Op delivery to execution core
    output reg  [1:0]        uop_count,
    output reg               uop_from_ucode,
    output reg               uop_trace_cont,
    output reg               uop_flush,
    // Prediction result
    output reg               pred_valid,
    output reg               pred_taken,
    output reg  [AW-1:0]     pred_target,
    // Retire feedback
    input  wire              ret_valid,
    input  wire [AW-1:0]     ret_pc,
    input  wire [AW-1:0]     ret_target,
    input  wire              ret_taken,
    input  wire              mispredict,
    input  wire [AW-1:0]     fix_target,
    // Load speculation
    input  wire              ld_pred_dep,
    input  wire              ld_dep_false,
    input  wire              ld_mem_valid,
    output reg               ld_go,
    output reg               ld_use_store,
    // Slow unit dispatch
    input  wire              slow_req,
    output reg               slow_accept
);

    // ----------------------------------------------------------------
    // Target table with one-bit history
    // ----------------------------------------------------------------
    reg  [AW-1:0]  tgt   [0:TDEPTH-1];
    reg  [AW-1:0]  tag   [0:TDEPTH-1];
    reg  [TDEPTH-1:0] tvalid;
    reg  [TDEPTH-1:0] hist;
    wire [TIW-1:0] look_idx = fetch_addr[`FFBP_CHUNK_LSB+TIW-1:`FFBP_CHUNK_LSB];
    wire [TIW-1:0] dec_idx  = dec_pc[`FFBP_CHUNK_LSB+TIW-1:`FFBP_CHUNK_LSB];
    wire [TIW-1:0] upd_idx  = ret_pc[`FFBP_CHUNK_LSB+TIW-1:`FFBP_CHUNK_LSB];
    wire           look_hit = tvalid[look_idx] && tag[look_idx] == fetch_addr;
    wire           dec_hit  = tvalid[dec_idx] && tag[dec_idx] == dec_pc;
    wire           upd      = ce && ret_valid && !mispredict;

    genvar i;
    generate
        for (i = 0; i < TDEPTH; i = i + 1) begin : g_tab
            localparam integer IDX = i;
            always @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    tgt[i]    <= {AW{1'b0}};
                    tag[i]    <= {AW{1'b0}};
                    tvalid[i] <= 1'b0;
                    hist[i]   <= 1'b0;
                end else if (upd && upd_idx == IDX[TIW-1:0]) begin
                    tgt[i]    <= ret_target;
                    tag[i]    <= ret_pc;
                    tvalid[i] <= 1'b1;
                    hist[i]   <= ret_taken;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Return stack
    // ----------------------------------------------------------------
    wire          take     = ce && dec_valid && dec_ready;
    wire [AW-1:0] ret_addr = dec_pc + `FFBP_CHUNK_BYTES;
    wire [AW-1:0] ras_top;
    wire          ras_ok;

    ffbp_ras #(
        .DEPTH (`FFBP_RAS_DEPTH),
        .AW    (AW),
        .PW    (4)
    ) u_ras (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .push      (take && dec_kind == `FFBP_BR_CALL),
        .pop       (take && dec_kind == `FFBP_BR_RET),
        .flush     (mispredict),
        .push_addr (ret_addr),
        .top_addr  (ras_top),
        .top_valid (ras_ok)
    );

    // ----------------------------------------------------------------
    // Prediction of the decoded branch
    // ----------------------------------------------------------------
    reg          next_taken;
    reg          next_pv;
    reg [AW-1:0] next_target;
    wire [AW-1:0] disp_tgt = dec_pc + dec_disp;

    always @* begin
        next_pv     = 1'b0;
        next_taken  = 1'b0;
        next_target = {AW{1'b0}};
        case (dec_kind)
            `FFBP_BR_COND: begin
                next_pv = 1'b1;
                if (dec_hit) begin
                    next_taken  = hist[dec_idx];
                    next_target = tgt[dec_idx];
                end else begin
                    next_taken  = dec_disp[AW-1];
                    next_target = disp_tgt;
                end
            end
            `FFBP_BR_CALL: begin
                next_pv     = 1'b1;
                next_taken  = 1'b1;
                next_target = dec_hit ? tgt[dec_idx] : disp_tgt;
            end
            `FFBP_BR_RET: begin
                next_pv     = 1'b1;
                next_taken  = 1'b1;
                next_target = ras_ok ? ras_top : tgt[dec_idx];
            end
            `FFBP_BR_INDIR: begin
                next_pv     = dec_hit;
                next_taken  = dec_hit;
                next_target = tgt[dec_idx];
            end
            default: begin
                // Far transfers and non-branches get no prediction
                next_pv = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Fetch sequencer
    // ----------------------------------------------------------------
    localparam [2:0] ST_RUN  = 3'b001;
    localparam [2:0] ST_MISS = 3'b010;
    localparam [2:0] ST_SECT = 3'b100;
    reg [2:0] state;
    // Sector mate: flip the line bit inside the aligned 128-byte sector
    wire [AW-1:0] mate = fetch_addr ^ ({{(AW-1){1'b0}}, 1'b1} << `FFBP_LINE_LSB);
    wire [AW-1:0] chunk_base = {fetch_addr[AW-1:`FFBP_CHUNK_LSB], {`FFBP_CHUNK_LSB{1'b0}}};

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state       <= ST_RUN;
            fetch_req   <= 1'b0;
            fetch_addr  <= {AW{1'b0}};
            sector_req  <= 1'b0;
            sector_addr <= {AW{1'b0}};
        end else if (ce) begin
            sector_req <= 1'b0;
            fetch_req  <= 1'b1;
            if (mispredict) begin
                state      <= ST_RUN;
                fetch_addr <= fix_target;
            end else begin
                case (state)
                    ST_RUN: begin
                        if (fetch_ack && fetch_miss) begin
                            state       <= ST_MISS;
                            sector_req  <= 1'b1;
                            sector_addr <= mate;
                        end else if (take && next_pv && next_taken) begin
                            fetch_addr <= next_target;
                        end else if (fetch_ack && look_hit && hist[look_idx]) begin
                            fetch_addr <= tgt[look_idx];
                        end else if (fetch_ack) begin
                            fetch_addr <= chunk_base + `FFBP_CHUNK_BYTES;
                        end
                    end
                    ST_MISS: begin
                        // Hold the missing chunk until memory answers
                        if (fetch_ack && !fetch_miss)
                            state <= ST_SECT;
                    end
                    ST_SECT: begin
                        state      <= ST_RUN;
                        fetch_addr <= chunk_base + `FFBP_CHUNK_BYTES;
                    end
                    default: state <= ST_RUN;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Decode and op delivery
    // ----------------------------------------------------------------
    reg ucode_busy;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dec_ready      <= 1'b0;
            ucode_busy     <= 1'b0;
            uop_count      <= 2'h0;
            uop_from_ucode <= 1'b0;
            uop_trace_cont <= 1'b0;
            uop_flush      <= 1'b0;
            pred_valid     <= 1'b0;
            pred_taken     <= 1'b0;
            pred_target    <= {AW{1'b0}};
        end else if (ce) begin
            uop_flush  <= mispredict;
            // An op decoded in the redirect cycle is younger and gets dropped
            pred_valid <= take && next_pv && !mispredict;
            pred_taken <= next_taken;
            pred_target <= next_target;
            // Microcode costs a stall cycle on the single decoder
            ucode_busy <= take && (dec_complex || !dec_trace_hit);
            dec_ready  <= !(take && (dec_complex || !dec_trace_hit)) && !mispredict;
            if (take && !mispredict) begin
                uop_from_ucode <= dec_complex || !dec_trace_hit;
                if (dec_trace_count > UOPS[1:0])
                    uop_count <= UOPS[1:0];
                else
                    uop_count <= dec_trace_count;
                uop_trace_cont <= next_pv && next_taken && dec_trace_hit;
            end else begin
                uop_count      <= 2'h0;
                uop_from_ucode <= ucode_busy;
                uop_trace_cont <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Load speculation and slow-unit spacing
    // ----------------------------------------------------------------
    reg ld_wait;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ld_wait      <= 1'b0;
            ld_go        <= 1'b0;
            ld_use_store <= 1'b0;
            slow_accept  <= 1'b0;
        end else if (ce) begin
            slow_accept <= slow_req && !slow_accept;
            if (ld_wait) begin
                ld_go        <= ld_mem_valid;
                ld_use_store <= 1'b0;
                ld_wait      <= !ld_mem_valid;
            end else if (ld_pred_dep && ld_dep_false) begin
                ld_go   <= 1'b0;
                ld_wait <= 1'b1;
                ld_use_store <= 1'b0;
            end else begin
                ld_go        <= ld_pred_dep;
                ld_use_store <= ld_pred_dep;
            end
        end
    end

endmodule // ffbp_frontend

// file: sim/ffbp_frontend_props.sv
// Concurrent checks on the front end's ports.
// Assumes it is bound into ffbp_frontend and that everything runs on clk.
`timescale 1ns/1ps
`include "ffbp_regs.vh"

module ffbp_frontend_props #(
    parameter AW = 32
) (
    // Clock and reset
    input wire          clk,
    input wire          nrst,
    input wire          ce,
    // Fetch side
    input wire          fetch_ack,
    input wire          fetch_miss,
    input wire [AW-1:0] fetch_addr,
    input wire          sector_req,
    input wire [AW-1:0] sector_addr,
    // Decoder
    input wire          dec_valid,
    input wire          dec_ready,
    input wire [2:0]    dec_kind,
    input wire          dec_complex,
    input wire          dec_trace_hit,
    input wire [1:0]    dec_trace_count,
    // Delivery and prediction
    input wire [1:0]    uop_count,
    input wire          uop_from_ucode,
    input wire          uop_trace_cont,
    input wire          uop_flush,
    input wire          pred_valid,
    input wire          pred_taken,
    input wire [AW-1:0] pred_target,
    input wire          mispredict,
    input wire [AW-1:0] fix_target,
    // Load and slow unit
    input wire          ld_pred_dep,
    input wire          ld_dep_false,
    input wire          ld_mem_valid,
    input wire          ld_go,
    input wire          slow_accept
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    wire take = ce & dec_valid & dec_ready;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_flush;
        ce & mispredict |=> uop_flush && !dec_ready && fetch_addr == $past(fix_target);
    endproperty
    a_flush: assert property (p_flush) else $error("flush did not redirect");
    property p_sector;
        ce & fetch_ack & fetch_miss & !mispredict |=>
            sector_req && sector_addr == (fetch_addr ^ 32'h40);
    endproperty
    a_sector: assert property (p_sector) else $error("sector mate not fetched");
    property p_far;
        take & dec_kind == `FFBP_BR_FAR |=> !pred_valid;
    endproperty
    a_far: assert property (p_far) else $error("far transfer predicted");
    property p_ret;
        take & !mispredict & dec_kind == `FFBP_BR_RET |=> !pred_valid || pred_taken;
    endproperty
    a_ret: assert property (p_ret) else $error("return predicted not taken");
    property p_ucode;
        take & !mispredict & (dec_complex | !dec_trace_hit) |=> uop_from_ucode && !dec_ready;
    endproperty
    a_ucode: assert property (p_ucode) else $error("microcode flow missing");
    property p_count;
        take & !mispredict & dec_trace_hit & !dec_complex |=>
            uop_count == $past(dec_trace_count) && !uop_from_ucode;
    endproperty
    a_count: assert property (p_count) else $error("op count wrong");
    property p_one;
        pred_valid |-> $past(take);
    endproperty
    a_one: assert property (p_one) else $error("prediction without decode");
    property p_taken;
        pred_valid & pred_taken |-> fetch_addr == pred_target;
    endproperty
    a_taken: assert property (p_taken) else $error("fetch not on predicted path");
    property p_trace;
        uop_trace_cont |-> pred_valid && pred_taken;
    endproperty
    a_trace: assert property (p_trace) else $error("trace continued untaken");
    property p_slow;
        slow_accept |=> !slow_accept;
    endproperty
    a_slow: assert property (p_slow) else $error("slow unit took back to back");
    property p_ld;
        ce & ld_pred_dep & !ld_dep_false |=> ld_go;
    endproperty
    a_ld: assert property (p_ld) else $error("dependent load did not go");
    property p_hold;
        ce & ld_dep_false & !ld_mem_valid |=> !ld_go;
    endproperty
    a_hold: assert property (p_hold) else $error("false dependence not held");

    c_flush: cover property (ce & mispredict);
    c_miss:  cover property (sector_req);
    c_taken: cover property (pred_valid & pred_taken);
endmodule // ffbp_frontend_props

bind ffbp_frontend ffbp_frontend_props #(.AW(AW)) u_props (.*);

// file: sim/ffbp_retire_model.sv
// Model of the execution core's retirement side feeding branch outcomes back.
// Assumes the bench calls send() from its main sequence; drives on falling edges.
`timescale 1ns/1ps

module ffbp_retire_model (
    // Clock
    input  wire         clk,
    // Retire feedback
    output logic        ret_valid,
    output logic [31:0] ret_pc,
    output logic [31:0] ret_target,
    output logic        ret_taken,
    output logic        mispredict,
    output logic [31:0] fix_target
);
    initial {ret_valid, ret_pc, ret_target, ret_taken, mispredict, fix_target} = '0;

    // One-cycle pulse; on release ret_pc and fix_target are inverted so stale values cannot pass
    task send(input logic m, input logic [31:0] pc, input logic [31:0] t);
        @(negedge clk);
        if (m) {mispredict, fix_target} = {1'b1, t};
        else {ret_valid, ret_pc, ret_target, ret_taken} = {1'b1, pc, t, 1'b1};
        @(negedge clk);
        {ret_valid, mispredict, ret_pc, fix_target} = {2'b00, ~ret_pc, ~fix_target};
    endtask
endmodule // ffbp_retire_model

// file: sim/ffbp_frontend_tb.sv
// Self-checking bench for the fetch and branch-prediction front end.
// Assumes the retire model as far side; the bench stands in for memory.
`timescale 1ns/1ps
`include "ffbp_regs.vh"

module ffbp_frontend_tb;
    logic        clk, nrst, ce, fetch_ack, fetch_miss, dec_valid, dec_complex, dec_trace_hit;
    logic        ld_pred_dep, ld_dep_false, ld_mem_valid, slow_req;
    logic [2:0]  dec_kind;
    logic [1:0]  dec_trace_count;
    logic [31:0] dec_pc, dec_disp;
    wire         fetch_req, sector_req, dec_ready, uop_from_ucode, uop_trace_cont, uop_flush;
    wire         pred_valid, pred_taken, ld_go, ld_use_store, slow_accept;
    wire         ret_valid, ret_taken, mispredict;
    wire  [1:0]  uop_count;
    wire  [31:0] fetch_addr, sector_addr, pred_target, ret_pc, ret_target, fix_target;
    int          failures, samples_checked, cycles;

    ffbp_frontend u_dut (.*);
    ffbp_retire_model u_core (.*);

    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end

    // Ceiling well above the roughly 60 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end

    task close_out();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask

    task dec(input logic [2:0] k, input logic [31:0] pc, input logic [31:0] d,
             input logic cx, input logic hit, input logic [1:0] cnt);
        @(negedge clk);
        while (dec_ready !== 1'b1) @(negedge clk);
        {dec_kind, dec_pc, dec_disp, dec_complex, dec_trace_hit, dec_trace_count, dec_valid} =
            {k, pc, d, cx, hit, cnt, 1'b1};
        @(negedge clk);
        dec_valid = 0;
    endtask

    task pred(input logic t, input logic [31:0] tg);
        chk("pred_valid", 1, pred_valid);
        chk("pred_taken", t, pred_taken);
        chk("pred_target", tg, pred_target);
        chk("fetch_addr", tg, fetch_addr);
    endtask

    task ack(input logic m);
        @(negedge clk);
        {fetch_ack, fetch_miss} = {1'b1, m};
        @(negedge clk);
        fetch_ack = 0;
    endtask

    task t_static();
        dec(`FFBP_BR_COND, 32'h1000, 32'hffffffc0, 0, 1, 1);
        pred(1, 32'h00000fc0);
        dec(`FFBP_BR_COND, 32'h1100, 32'h40, 0, 1, 1);
        chk("pred_taken", 0, pred_taken);
        dec(`FFBP_BR_FAR, 32'h1200, 32'hffffff00, 0, 1, 1);
        chk("pred_valid", 0, pred_valid);
        dec(`FFBP_BR_INDIR, 32'h1300, 32'h0, 0, 1, 1);
        chk("pred_valid", 0, pred_valid);
        $display("test static done");
    endtask

    task t_calls();
        dec(`FFBP_BR_CALL, 32'h2000, 32'h400, 0, 1, 1);
        pred(1, 32'h2400);
        dec(`FFBP_BR_CALL, 32'h2400, 32'h200, 0, 1, 1);
        pred(1, 32'h2600);
        dec(`FFBP_BR_RET, 32'h2610, 32'h0, 0, 1, 1);
        pred(1, 32'h2420);
        dec(`FFBP_BR_RET, 32'h2430, 32'h0, 0, 1, 1);
        pred(1, 32'h2020);
        $display("test calls done");
    endtask

    task t_fetch();
        dec(`FFBP_BR_CALL, 32'h4000, 32'h1c0, 0, 1, 1);
        pred(1, 32'h41c0);
        ack(0);
        chk("fetch_addr", 32'h41e0, fetch_addr);
        ack(1);
        chk("sector_req", 1, sector_req);
        chk("sector_addr", 32'h41a0, sector_addr);
        chk("fetch_addr", 32'h41e0, fetch_addr);
        ack(0);
        chk("fetch_addr", 32'h41e0, fetch_addr);
        @(negedge clk);
        chk("fetch_addr", 32'h4200, fetch_addr);
        $display("test fetch done");
    endtask

    task t_retire();
        u_core.send(0, 32'h3000, 32'h5000);
        dec(`FFBP_BR_COND, 32'h3000, 32'h40, 0, 1, 1);
        pred(1, 32'h5000);
        $display("test retire done");
    endtask

    task t_ops();
        dec(`FFBP_BR_NONE, 32'h5000, 32'h0, 1, 1, 1);
        chk("uop_from_ucode", 1, uop_from_ucode);
        chk("dec_ready", 0, dec_ready);
        dec(`FFBP_BR_NONE, 32'h5004, 32'h0, 0, 1, 3);
        chk("uop_count", 3, uop_count);
        chk("uop_from_ucode", 0, uop_from_ucode);
        dec(`FFBP_BR_NONE, 32'h5008, 32'h0, 0, 0, 0);
        chk("uop_from_ucode", 1, uop_from_ucode);
        dec(`FFBP_BR_COND, 32'h5100, 32'hffffffe0, 0, 1, 2);
        chk("uop_trace_cont", 1, uop_trace_cont);
        $display("test ops done");
    endtask

    task t_misp();
        u_core.send(1, 32'h0, 32'h6000);
        chk("fetch_addr", 32'h6000, fetch_addr);
        chk("uop_flush", 1, uop_flush);
        chk("dec_ready", 0, dec_ready);
        ce = 0;
        @(negedge clk) chk("uop_flush", 1, uop_flush);
        ce = 1;
        $display("test mispredict done");
    endtask

    task t_load_slow();
        @(negedge clk) ld_pred_dep = 1;
        @(negedge clk) ld_pred_dep = 0;
        chk("ld_go", 1, ld_go);
        chk("ld_use_store", 1, ld_use_store);
        @(negedge clk) {ld_pred_dep, ld_dep_false} = 2'b11;
        @(negedge clk) {ld_pred_dep, ld_dep_false} = 2'b00;
        chk("ld_go", 0, ld_go);
        @(negedge clk) ld_mem_valid = 1;
        chk("ld_go", 0, ld_go);
        @(negedge clk) ld_mem_valid = 0;
        chk("ld_go", 1, ld_go);
        slow_req = 1;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            chk("slow_accept", i % 2 == 0, slow_accept);
        end
        slow_req = 0;
        $display("test load and slow unit done");
    endtask

    initial begin
        {nrst, fetch_ack, fetch_miss, dec_valid, dec_complex, dec_trace_hit} = '0;
        {ld_pred_dep, ld_dep_false, ld_mem_valid, slow_req, dec_kind, dec_trace_count} = '0;
        {dec_pc, dec_disp, ce} = {64'h0, 1'b1};
        repeat (10) @(negedge clk);
        chk("fetch_req", 0, fetch_req);
        nrst = 1;
        repeat (2) @(negedge clk);
        chk("fetch_req", 1, fetch_req);
        chk("dec_ready", 1, dec_ready);
        t_static();
        t_calls();
        t_fetch();
        t_retire();
        t_ops();
        t_misp();
        t_load_slow();
        close_out();
    end
endmodule // ffbp_frontend_tb
